// >>> bench/aso_rx_model.sv
`timescale 1ns/1ps
`default_nettype none

module aso_rx_model (
  input  wire logic         clk_sys_i,
  input  wire logic [7:0]   data_i,
  input  wire logic         bit_clk_i,
  input  wire logic         word_clk_i,
  output logic              word_valid_o,
  output logic [111:0]      word_o,
  output logic [2:0]        clk_delay_o
);
  int   idx    = 0;
  logic wclk_q = 1'b0;
  logic bclk_q = 1'b0;

  initial begin
    word_valid_o = 1'b0;
    word_o = '0;
    clk_delay_o = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cells are taken three clocks in, so either side has margin
  always @(posedge clk_sys_i) begin
    word_valid_o <= 1'b0;
    idx = (word_clk_i && !wclk_q) ? 0 : idx + 1;
    // Bit clock offset from the data edge, seen only in the first cell
    if (bit_clk_i && !bclk_q && idx < 6)
      clk_delay_o <= 3'(idx);
    if (idx % 6 == 3 && idx < 84)
      for (int c = 0; c < 8; c++)
        word_o[c*14 + 13 - idx/6] <= data_i[c];
    if (idx == 81)
      word_valid_o <= 1'b1;
    wclk_q = word_clk_i;
    bclk_q = bit_clk_i;
  end
endmodule : aso_rx_model

`default_nettype wire

// >>> bench/aso_serial_output_config_bench.sv
`timescale 1ns/1ps
`default_nettype none

module aso_serial_output_config_bench;
  logic         clk_sys_i = 1'b0;
  logic         rstn_i    = 1'b0;
  logic         sclk_i    = 1'b0;
  logic         csb_n_i   = 1'b1;
  logic         tb_sdio   = 1'b0;
  wire          sdio_i;
  logic         sdio_o;
  logic         sdio_oe_o;
  logic [111:0] sample_i  = '0;
  logic         sample_take_o;
  logic [7:0]   data_o;
  logic         fwd_bit_clk;
  logic         fwd_word_clk;
  logic         lvds_low_power_o;
  logic [1:0]   term_sel_o;
  logic [7:0]   drive_double_o;
  logic         rx_valid;
  logic [111:0] rx_word;
  logic [2:0]   rx_delay;
  logic [31:0]  seed = 32'h5755;
  logic [31:0]  r;
  logic [7:0]   sel, inv, dbl, rd;
  logic [1:0]   fmt;
  logic [2:0]   fs;
  logic         wclk_seen  = 1'b0;
  logic [13:0]  w;
  logic [111:0] e;
  logic [111:0] exp_q[$];
  int           n_mismatch = 0;
  int           checked    = 0;
  int           cycles     = 0;

  // Shared data line: the device wins while it drives
  assign sdio_i = sdio_oe_o ? sdio_o : tb_sdio;

  aso_serial_output_config dut (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .sclk_i(sclk_i),
    .csb_n_i(csb_n_i), .sdio_i(sdio_i), .sdio_o(sdio_o),
    .sdio_oe_o(sdio_oe_o), .sample_i(sample_i),
    .sample_take_o(sample_take_o), .data_o(data_o),
    .forwarded_bit_clock_o(fwd_bit_clk),
    .forwarded_word_clock_o(fwd_word_clk),
    .lvds_low_power_o(lvds_low_power_o), .term_sel_o(term_sel_o),
    .drive_double_o(drive_double_o));

  aso_rx_model rx (
    .clk_sys_i(clk_sys_i), .data_i(data_o), .bit_clk_i(fwd_bit_clk),
    .word_clk_i(fwd_word_clk), .word_valid_o(rx_valid),
    .word_o(rx_word), .clk_delay_o(rx_delay));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic print_verdict();
    if (n_mismatch == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  task automatic cmp(input logic [111:0] got, input logic [111:0] want);
    checked++;
    if (got !== want) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h want %h", $time, got, want);
    end
  endtask : cmp

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : wait_clk

  task automatic wait_take(input int n);
    repeat (n) begin
      @(negedge clk_sys_i);
      repeat (90) if (sample_take_o !== 1'b1) @(negedge clk_sys_i);
    end
  endtask : wait_take

  // Serial clock levels last four system clocks; the port needs two
  task automatic spi(input logic rw, input logic [12:0] a,
                     input logic [7:0] wd);
    logic [23:0] v;
    v = {rw, 2'b00, a, wd};
    rd = 8'h00;
    @(negedge clk_sys_i);
    csb_n_i = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      tb_sdio = v[i];
      wait_clk(4);
      sclk_i = 1'b1;
      wait_clk(4);
      if (rw && i >= 1 && i <= 8)
        rd[i-1] = (sdio_oe_o === 1'b1) ? sdio_o : 1'bx;
      sclk_i = 1'b0;
    end
    wait_clk(4);
    csb_n_i = 1'b1;
    wait_clk(4);
  endtask : spi

  task automatic rdchk(input logic [12:0] a, input logic [7:0] want);
    spi(1'b1, a, 8'h00);
    cmp(rd, want);
  endtask : rdchk

  task automatic delay_chk(input logic [2:0] want);
    wait_take(2);
    wait_clk(8);
    cmp(rx_delay, want);
  endtask : delay_chk

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  always @(negedge clk_sys_i) begin
    if (rx_valid === 1'b1 && exp_q.size() > 0)
      cmp(rx_word, exp_q.pop_front());
    // Sample pick-up must coincide with the start of a frame
    if (sample_take_o === 1'b1)
      cmp({wclk_seen, fwd_word_clk}, 112'h1);
    wclk_seen = fwd_word_clk;
  end

  initial begin
    inv = 8'h00;
    dbl = 8'h00;
    wait_clk(12);
    rstn_i = 1'b1;
    wait_clk(2);
    rdchk(aso_pkg::ADDR_FORMAT, 8'h00);
    rdchk(aso_pkg::ADDR_DRIVER, 8'h00);
    rdchk(aso_pkg::ADDR_PHASE, 8'h03);
    rdchk(13'h0017, 8'h00);
    delay_chk(3'h3);
    for (int p = 0; p <= 10; p++) begin
      spi(1'b0, aso_pkg::ADDR_PHASE, 8'(p));
      rdchk(aso_pkg::ADDR_PHASE, 8'(p));
      delay_chk(3'(p % 6));
    end
    // Codes past the top step must leave the last one in place
    spi(1'b0, aso_pkg::ADDR_PHASE, 8'h0B);
    rdchk(aso_pkg::ADDR_PHASE, 8'h0A);
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      r = seed;
      sel = r[7:0];
      fmt = 2'(k % 3);
      for (int j = 0; j < 4; j++) begin
        seed = lfsr(seed);
        sample_i[j*28 +: 28] = seed[27:0];
      end
      inv = r[9] ? (inv | sel) : (inv & ~sel);
      dbl = r[10] ? (dbl | sel) : (dbl & ~sel);
      spi(1'b0, aso_pkg::ADDR_CHAN_SEL, sel);
      spi(1'b0, aso_pkg::ADDR_FORMAT, {1'b0, r[8], 3'b000, r[9], fmt});
      spi(1'b0, aso_pkg::ADDR_DRIVER, {2'b00, r[13:12], 3'b000, r[10]});
      cmp(lvds_low_power_o, r[8]);
      cmp(term_sel_o, r[13:12]);
      cmp(drive_double_o, dbl);
      // Readback shows the local bit of the lowest selected channel
      fs = 3'h0;
      for (int c = 7; c >= 0; c--)
        if (sel[c])
          fs = 3'(c);
      rdchk(aso_pkg::ADDR_FORMAT, {1'h0, r[8], 3'h0, inv[fs], fmt});
      wait_take(2);
      for (int c = 0; c < 8; c++) begin
        w = sample_i[c*14 +: 14];
        if (fmt == 2'h1) w[13] = ~w[13];
        if (inv[c]) w = ~w;
        e[c*14 +: 14] = w;
      end
      // Phase is left at its top code here, so data timing is exercised
      exp_q.push_back(e);
      wait_take(1);
    end
    wait_clk(4);
    cmp(112'(exp_q.size()), 112'h0);
    print_verdict();
  end
endmodule : aso_serial_output_config_bench

`default_nettype wire

// >>> rtl/aso_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none

interface aso_cfg_if;
  logic        wr_stb;
  logic [12:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;

  modport port (output wr_stb, output addr, output wdata, input rdata);
  modport regs (input wr_stb, input addr, input wdata, output rdata);
endinterface : aso_cfg_if

`default_nettype wire

// >>> rtl/aso_pkg.sv
`default_nettype none

package aso_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Geometry
  localparam int NUM_CH   = 8;
  localparam int SAMPLE_W = 14;
  localparam int ADDR_W   = 13;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [12:0] ADDR_CHAN_SEL = 13'h0005;
  localparam logic [12:0] ADDR_FORMAT   = 13'h0014;
  localparam logic [12:0] ADDR_DRIVER   = 13'h0015;
  localparam logic [12:0] ADDR_PHASE    = 13'h0016;

  // Reset values
  localparam logic [7:0] RST_CHAN_SEL = 8'hFF;
  localparam logic [7:0] RST_FORMAT   = 8'h00;
  localparam logic [7:0] RST_DRIVER   = 8'h00;
  localparam logic [7:0] RST_PHASE    = 8'h03;

  // Field positions and codes
  localparam int         FMT_SEL_LSB     = 0;
  localparam int         FMT_INV_BIT     = 2;
  localparam int         FMT_STD_BIT     = 6;
  localparam logic [7:0] FMT_GLOBAL_MASK = 8'hFB;
  localparam logic [1:0] FMT_OFFSET_BIN  = 2'h0;
  localparam logic [1:0] FMT_TWOS        = 2'h1;
  localparam int         DRV_DOUBLE_BIT  = 0;
  localparam int         DRV_TERM_LSB    = 4;
  localparam logic [7:0] DRV_GLOBAL_MASK = 8'hFE;
  localparam logic [3:0] PHASE_MAX       = 4'hA;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: one bit time spans six system clocks, one clock per 60 degrees
  localparam int SYS_PERIOD_NS  = 40;
  localparam int BIT_PERIOD_NS  = 240;
  localparam int PHASES_PER_BIT = BIT_PERIOD_NS / SYS_PERIOD_NS;
  localparam logic [2:0] PH_LAST  = 3'(PHASES_PER_BIT - 1);
  localparam logic [2:0] PH_HALF  = 3'(PHASES_PER_BIT / 2);
  localparam logic [3:0] BIT_LAST = 4'(SAMPLE_W - 1);
  localparam logic [3:0] BIT_HALF = 4'(SAMPLE_W / 2);

  // Control port framing
  localparam logic [4:0] INSTR_LAST = 5'h0F;
  localparam logic [4:0] DATA_LAST  = 5'h07;
  localparam int         RW_BIT     = 15;

  typedef enum logic [2:0] {
    SPI_IDLE,
    SPI_INSTR,
    SPI_WRITE,
    SPI_READ,
    SPI_DONE
  } aso_spi_e;

endpackage : aso_pkg

`default_nettype wire

// >>> rtl/aso_serial_output_config.sv
// Functional notes
// - Format field: 00 offset binary, 01 twos
// - Inversion bit per channel; other format bits global
// - Drive doubling bit per channel; rest global
// - Phase codes 0 to 10, 60 degrees each
// - Phase resets to code 3, 180 degrees
// - Phase moves forwarded clock only, not data
`timescale 1ns/1ps
`default_nettype none

module aso_serial_output_config (
  input  wire logic          clk_sys_i,
  input  wire logic          rstn_i,
  input  wire logic          sclk_i,
  input  wire logic          csb_n_i,
  input  wire logic          sdio_i,
  output logic               sdio_o,
  output logic               sdio_oe_o,
  input  wire logic [111:0]  sample_i,
  output logic               sample_take_o,
  output logic [7:0]         data_o,
  output logic               forwarded_bit_clock_o,
  output logic               forwarded_word_clock_o,
  output logic               lvds_low_power_o,
  output logic [1:0]         term_sel_o,
  output logic [7:0]         drive_double_o
);

  localparam int NCH = aso_pkg::NUM_CH;
  localparam int SW  = aso_pkg::SAMPLE_W;

  aso_cfg_if cfg ();

  aso_spi_port u_port (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .sclk_i    (sclk_i),
    .csb_n_i   (csb_n_i),
    .sdio_i    (sdio_i),
    .sdio_o    (sdio_o),
    .sdio_oe_o (sdio_oe_o),
    .cfg       (cfg)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  logic [7:0] chan_sel,   next_chan_sel;
  logic [7:0] fmt_global, next_fmt_global;
  logic [7:0] drv_global, next_drv_global;
  logic [7:0] inv_en,     next_inv_en;
  logic [7:0] drv_double, next_drv_double;
  logic [3:0] phase_code, next_phase_code;
  logic [1:0] fmt_sel;

  // Lowest selected channel supplies the local bit on readback
  function automatic logic [2:0] first_sel(input logic [7:0] sel);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (sel[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction : first_sel

  always_comb begin
    next_chan_sel   = chan_sel;
    next_fmt_global = fmt_global;
    next_drv_global = drv_global;
    next_inv_en     = inv_en;
    next_drv_double = drv_double;
    next_phase_code = phase_code;
    if (cfg.wr_stb) begin
      if (cfg.addr == aso_pkg::ADDR_CHAN_SEL) begin
        next_chan_sel = cfg.wdata;
      end else if (cfg.addr == aso_pkg::ADDR_FORMAT) begin
        next_fmt_global = cfg.wdata & aso_pkg::FMT_GLOBAL_MASK;
        for (int i = 0; i < NCH; i++) begin
          if (chan_sel[i]) begin
            next_inv_en[i] = cfg.wdata[aso_pkg::FMT_INV_BIT];
          end
        end
      end else if (cfg.addr == aso_pkg::ADDR_DRIVER) begin
        next_drv_global = cfg.wdata & aso_pkg::DRV_GLOBAL_MASK;
        for (int i = 0; i < NCH; i++) begin
          if (chan_sel[i]) begin
            next_drv_double[i] = cfg.wdata[aso_pkg::DRV_DOUBLE_BIT];
          end
        end
      end else if (cfg.addr == aso_pkg::ADDR_PHASE) begin
        // Codes above the last legal step are dropped, old phase stays
        if (cfg.wdata[3:0] <= aso_pkg::PHASE_MAX) begin
          next_phase_code = cfg.wdata[3:0];
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      chan_sel   <= aso_pkg::RST_CHAN_SEL;
      fmt_global <= aso_pkg::RST_FORMAT & aso_pkg::FMT_GLOBAL_MASK;
      drv_global <= aso_pkg::RST_DRIVER & aso_pkg::DRV_GLOBAL_MASK;
      inv_en     <= {NCH{aso_pkg::RST_FORMAT[aso_pkg::FMT_INV_BIT]}};
      drv_double <= {NCH{aso_pkg::RST_DRIVER[aso_pkg::DRV_DOUBLE_BIT]}};
      phase_code <= aso_pkg::RST_PHASE[3:0];
    end else begin
      chan_sel   <= next_chan_sel;
      fmt_global <= next_fmt_global;
      drv_global <= next_drv_global;
      inv_en     <= next_inv_en;
      drv_double <= next_drv_double;
      phase_code <= next_phase_code;
    end
  end

  assign fmt_sel = fmt_global[aso_pkg::FMT_SEL_LSB +: 2];

  always_comb begin
    cfg.rdata = 8'h00;
    if (cfg.addr == aso_pkg::ADDR_CHAN_SEL) begin
      cfg.rdata = chan_sel;
    end else if (cfg.addr == aso_pkg::ADDR_FORMAT) begin
      cfg.rdata = fmt_global;
      cfg.rdata[aso_pkg::FMT_INV_BIT] = inv_en[first_sel(chan_sel)];
    end else if (cfg.addr == aso_pkg::ADDR_DRIVER) begin
      cfg.rdata = drv_global;
      cfg.rdata[aso_pkg::DRV_DOUBLE_BIT] = drv_double[first_sel(chan_sel)];
    end else if (cfg.addr == aso_pkg::ADDR_PHASE) begin
      cfg.rdata = {4'h0, phase_code};
    end
  end

  assign lvds_low_power_o = fmt_global[aso_pkg::FMT_STD_BIT];
  assign term_sel_o       = drv_global[aso_pkg::DRV_TERM_LSB +: 2];
  assign drive_double_o   = drv_double;

  ////////////////////////////////////////////////////////////////////////////
  // Bit and word timing from the system clock; phase code delays the forwarded bit clock

  logic [2:0]  ph,       next_ph;
  logic [3:0]  bit_idx,  next_bit_idx;
  logic        take,     next_take;
  logic        wclk,     next_wclk;
  logic        fclk,     next_fclk;
  logic [10:0] hist,     next_hist;
  logic [11:0] taps;
  logic        word_load;
  logic        next_base;

  assign word_load = (ph == aso_pkg::PH_LAST) && (bit_idx == aso_pkg::BIT_LAST);

  always_comb begin
    next_ph      = ph + 3'h1;
    next_bit_idx = bit_idx;
    if (ph == aso_pkg::PH_LAST) begin
      next_ph      = 3'h0;
      next_bit_idx = word_load ? 4'h0 : bit_idx + 4'h1;
    end
    next_take = word_load;
    next_wclk = next_bit_idx < aso_pkg::BIT_HALF;
    next_base = next_ph < aso_pkg::PH_HALF;
    next_hist = {hist[9:0], next_base};
    // Tap k is the undelayed bit clock held back k clocks of 60 degrees;
    // a long delay line trades a few flops for exact phase steps
    taps      = {hist, next_base};
    next_fclk = taps[phase_code];
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ph      <= 3'h0;
      bit_idx <= 4'h0;
      take    <= 1'b0;
      wclk    <= 1'b0;
      fclk    <= 1'b0;
      hist    <= 11'h000;
    end else begin
      ph      <= next_ph;
      bit_idx <= next_bit_idx;
      take    <= next_take;
      wclk    <= next_wclk;
      fclk    <= next_fclk;
      hist    <= next_hist;
    end
  end

  assign sample_take_o          = take;
  assign forwarded_word_clock_o = wclk;
  assign forwarded_bit_clock_o  = fclk;

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel formatting and serialiser

  function automatic logic [13:0] fmt_word(input logic [13:0] raw,
                                           input logic [1:0]  sel,
                                           input logic        inv);
    logic [13:0] w;
    w = raw;
    if (sel == aso_pkg::FMT_TWOS) begin
      w[13] = ~w[13];
    end
    if (inv) begin
      w = ~w;
    end
    return w;
  endfunction : fmt_word

  logic [13:0] sh [NCH];

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic [13:0] next_sh;
    always_comb begin
      next_sh = sh[c];
      if (word_load) begin
        next_sh = fmt_word(sample_i[c*SW +: SW], fmt_sel, inv_en[c]);
      end else if (ph == aso_pkg::PH_LAST) begin
        next_sh = {sh[c][12:0], 1'b0};
      end
    end
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
        sh[c] <= 14'h0000;
      end else begin
        sh[c] <= next_sh;
      end
    end
    assign data_o[c] = sh[c][13];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic after_rst;
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      after_rst <= 1'b0;
    end else begin
      after_rst <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  fmt_twos_a: assert property (
    word_load && fmt_sel == aso_pkg::FMT_TWOS && !inv_en[0]
    |=> sh[0] == {~$past(sample_i[13]), $past(sample_i[12:0])})
    else $error("twos complement word wrong");
  fmt_offset_a: assert property (
    word_load && fmt_sel == aso_pkg::FMT_OFFSET_BIN && !inv_en[0]
    |=> sh[0] == $past(sample_i[13:0]))
    else $error("offset binary word wrong");
  inv_local_a: assert property (
    cfg.wr_stb && cfg.addr == aso_pkg::ADDR_FORMAT
    |=> inv_en == (($past(chan_sel) & {NCH{$past(cfg.wdata[2])}})
                  | (~$past(chan_sel) & $past(inv_en))))
    else $error("inversion not local to selected channels");
  drv_local_a: assert property (
    cfg.wr_stb && cfg.addr == aso_pkg::ADDR_DRIVER && !chan_sel[1]
    |=> ##1 drive_double_o[1] == $past(drv_double[1], 2))
    else $error("drive doubling leaked to unselected channel");
  phase_range_a: assert property (
    cfg.wr_stb && cfg.addr == aso_pkg::ADDR_PHASE
    |=> phase_code == (($past(cfg.wdata[3:0]) <= 4'hA)
                       ? $past(cfg.wdata[3:0]) : $past(phase_code)))
    else $error("phase code write handled wrong");
  phase_rst_a: assert property (
    !after_rst |-> phase_code == 4'h3 && cfg.rdata[3:0] == phase_code
                   || cfg.addr != aso_pkg::ADDR_PHASE && phase_code == 4'h3)
    else $error("phase code not 180 degrees after reset");
  clk_delay_a: assert property (
    (phase_code == 4'h3 && $stable(phase_code)) [*5]
    |-> forwarded_bit_clock_o == $past(hist[0], 3))
    else $error("forwarded clock not delayed by three steps");
  data_phase_a: assert property (
    word_load |=> ph == 3'h0 && bit_idx == 4'h0 ##[5:5] ph == 3'h5)
    else $error("data timing moved");
  inv_data_a: assert property (
    word_load && inv_en[0] && fmt_sel == aso_pkg::FMT_OFFSET_BIN
    |=> sh[0] == ~$past(sample_i[13:0]))
    else $error("inverted word wrong");

  twos_load_c: cover property (word_load && fmt_sel == aso_pkg::FMT_TWOS);
  inv_write_c: cover property (cfg.wr_stb && cfg.addr == aso_pkg::ADDR_FORMAT
                               && cfg.wdata[2]);
  phase_max_c: cover property (phase_code == aso_pkg::PHASE_MAX);

endmodule : aso_serial_output_config

`default_nettype wire

// >>> rtl/aso_spi_port.sv
`timescale 1ns/1ps
`default_nettype none

module aso_spi_port (
  input  wire logic  clk_sys_i,
  input  wire logic  rstn_i,
  input  wire logic  sclk_i,
  input  wire logic  csb_n_i,
  input  wire logic  sdio_i,
  output logic       sdio_o,
  output logic       sdio_oe_o,
  aso_cfg_if.port    cfg
);

  aso_pkg::aso_spi_e state,   next_state;
  logic [4:0]        cnt,     next_cnt;
  logic [15:0]       shreg,   next_shreg;
  logic [7:0]        rd_sh,   next_rd_sh;
  logic [7:0]        wdata,   next_wdata;
  logic [12:0]       addr,    next_addr;
  logic              wr_stb,  next_wr_stb;
  logic              load_rd, next_load_rd;
  logic              oe,      next_oe;
  logic              sclk_q;
  logic              rise;
  logic              fall;

  // Pins are synchronous to the system clock, so edges come from one flop
  assign rise = sclk_i & ~sclk_q;
  assign fall = ~sclk_i & sclk_q;

  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_shreg   = shreg;
    next_rd_sh   = rd_sh;
    next_wdata   = wdata;
    next_addr    = addr;
    next_wr_stb  = 1'b0;
    next_load_rd = 1'b0;
    next_oe      = oe;
    if (csb_n_i) begin
      next_state = aso_pkg::SPI_IDLE;
      next_cnt   = 5'h00;
      next_oe    = 1'b0;
    end else begin
      case (state)
        aso_pkg::SPI_IDLE, aso_pkg::SPI_INSTR: begin
          if (rise) begin
            next_shreg = {shreg[14:0], sdio_i};
            next_cnt   = cnt + 5'h01;
            next_state = aso_pkg::SPI_INSTR;
            if (cnt == aso_pkg::INSTR_LAST) begin
              next_cnt  = 5'h00;
              next_addr = next_shreg[12:0];
              if (next_shreg[aso_pkg::RW_BIT]) begin
                next_state   = aso_pkg::SPI_READ;
                next_load_rd = 1'b1;
              end else begin
                next_state = aso_pkg::SPI_WRITE;
              end
            end
          end
        end
        aso_pkg::SPI_WRITE: begin
          if (rise) begin
            next_wdata = {wdata[6:0], sdio_i};
            next_cnt   = cnt + 5'h01;
            if (cnt == aso_pkg::DATA_LAST) begin
              next_wr_stb = 1'b1;
              next_state  = aso_pkg::SPI_DONE;
            end
          end
        end
        aso_pkg::SPI_READ: begin
          if (load_rd) begin
            next_rd_sh = cfg.rdata;
            next_oe    = 1'b1;
          end else if (fall) begin
            next_rd_sh = {rd_sh[6:0], 1'b0};
            next_cnt   = cnt + 5'h01;
            if (cnt == aso_pkg::DATA_LAST) begin
              next_oe    = 1'b0;
              next_state = aso_pkg::SPI_DONE;
            end
          end
        end
        default: begin
          next_state = aso_pkg::SPI_DONE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state   <= aso_pkg::SPI_IDLE;
      cnt     <= 5'h00;
      shreg   <= 16'h0000;
      rd_sh   <= 8'h00;
      wdata   <= 8'h00;
      addr    <= 13'h0000;
      wr_stb  <= 1'b0;
      load_rd <= 1'b0;
      oe      <= 1'b0;
      sclk_q  <= 1'b0;
    end else begin
      state   <= next_state;
      cnt     <= next_cnt;
      shreg   <= next_shreg;
      rd_sh   <= next_rd_sh;
      wdata   <= next_wdata;
      addr    <= next_addr;
      wr_stb  <= next_wr_stb;
      load_rd <= next_load_rd;
      oe      <= next_oe;
      sclk_q  <= sclk_i;
    end
  end

  assign sdio_o     = rd_sh[7];
  assign sdio_oe_o  = oe;
  assign cfg.wr_stb = wr_stb;
  assign cfg.addr   = addr;
  assign cfg.wdata  = wdata;

endmodule : aso_spi_port

`default_nettype wire
